// File: src/ppc_pkg.sv
package ppc_pkg;
  localparam logic [4:0] PPC_ADDR_P2_DIR  = 5'h01;
  localparam logic [4:0] PPC_ADDR_P2_DATA = 5'h03;
  localparam logic [4:0] PPC_ADDR_CTRL    = 5'h14;
  localparam logic [4:0] PPC_ADDR_P5_DATA = 5'h15;
  localparam logic [4:0] PPC_ADDR_P6_DIR  = 5'h16;
  localparam logic [4:0] PPC_ADDR_P6_DATA = 5'h17;
  localparam logic [31:0] PPC_EXT_MAP     = 32'h010000d4;
  localparam int PPC_CTRL_INT1  = 0;
  localparam int PPC_CTRL_INT2  = 1;
  localparam int PPC_CTRL_WAIT  = 2;
  localparam int PPC_CTRL_STOP  = 3;
  localparam int PPC_CTRL_RAM   = 6;
  localparam int PPC_CTRL_STBY  = 7;
  localparam logic [7:0] PPC_CTRL_WMASK = 8'hcf;
  localparam logic [7:0] PPC_CTRL_RST   = 8'h4c;
  localparam logic [1:0] PPC_P2_DIR_RST = 2'h0;
  localparam logic [7:0] PPC_P6_DIR_RST = 8'h00;
  localparam logic [7:0] PPC_P2_DIR_RD  = 8'hfc;
  localparam logic [7:0] PPC_BYTE_ZERO  = 8'h00;
  typedef struct packed {
    logic       int1_n;
    logic       int2_n;
    logic       mem_wait_n;
    logic       stop_n;
  } ppc_p5_func_t;
  typedef struct packed {
    logic       ext_int1_pin_enable;
    logic       ext_int2_pin_enable;
    logic       mem_wait_pin_enable;
    logic       stop_pin_enable;
    logic       internal_ram_enable;
    logic       standby_supply_flag;
  } ppc_ctrl_t;
endpackage

// File: src/ppc_pin_port.sv
`timescale 1ns/1ps
`default_nettype none
module ppc_pin_port
  import ppc_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [WIDTH-1:0] dir,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe,
  output logic      [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] latch_reg;
  // latch has no documented reset; zero keeps simulation defined
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      latch_reg <= '0;
    end else if (wr_en) begin
      latch_reg <= wr_data;
    end
  end
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign rd_data[i] = dir[i] ? latch_reg[i] : pin_in[i];
    end
  endgenerate
  assign pin_out = latch_reg;
  assign pin_oe  = dir;
endmodule
`default_nettype wire

// File: src/ppc_top.sv
`timescale 1ns/1ps
`default_nettype none
module ppc_top
  import ppc_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic [4:0] addr,
  input  wire logic       sel,
  input  wire logic       rd,
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  output logic            internal_hit,
  output logic            ext_pass,
  input  wire logic [7:0] p2_in,
  output logic      [7:0] p2_out,
  output logic      [7:0] p2_oe,
  input  wire logic [7:0] p2_func_own,
  input  wire logic [7:0] p2_func_oe,
  input  wire logic [7:0] p2_func_out,
  input  wire logic [7:0] p5_in,
  output ppc_p5_func_t    p5_func,
  output logic            wake_int1_ok,
  output logic            wake_int2_ok,
  input  wire logic [7:0] p6_in,
  output logic      [7:0] p6_out,
  output logic      [7:0] p6_oe,
  input  wire logic       supply_lost,
  output ppc_ctrl_t       ctrl,
  output logic            clk_stretch
);
  logic [1:0] p2_dir_reg;
  logic [7:0] p6_dir_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] rdata_reg;
  logic [7:0] p2_dir;
  logic [7:0] p2_rd;
  logic [7:0] p6_rd;
  logic [7:0] p2_lat;
  logic [7:0] p2_lat_oe;
  logic       acc;
  logic       is_ext;
  logic       wr_p2_dir;
  logic       wr_p2;
  logic       wr_ctrl;
  logic       wr_p6_dir;
  logic       wr_p6;

  assign acc       = sel && (rd || wr);
  assign is_ext    = PPC_EXT_MAP[addr];
  assign internal_hit = acc && !is_ext;
  assign ext_pass  = acc && is_ext;
  assign wr_p2_dir = sel && wr && (addr == PPC_ADDR_P2_DIR);
  assign wr_p2     = sel && wr && (addr == PPC_ADDR_P2_DATA);
  assign wr_ctrl   = sel && wr && (addr == PPC_ADDR_CTRL);
  assign wr_p6_dir = sel && wr && (addr == PPC_ADDR_P6_DIR);
  assign wr_p6     = sel && wr && (addr == PPC_ADDR_P6_DATA);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      p2_dir_reg <= PPC_P2_DIR_RST;
    end else if (wr_p2_dir) begin
      p2_dir_reg <= wdata[1:0];
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      p6_dir_reg <= PPC_P6_DIR_RST;
    end else if (wr_p6_dir) begin
      p6_dir_reg <= wdata;
    end
  end

  // supply loss clear wins over a simultaneous software write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= PPC_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wdata & PPC_CTRL_WMASK;
      end
      if (supply_lost) begin
        ctrl_reg[PPC_CTRL_STBY] <= 1'b0;
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_p2
      if (i == 0) begin : g_b0
        assign p2_dir[i] = p2_dir_reg[0];
        assign p2_oe[i]  = p2_lat_oe[i];
        assign p2_out[i] = p2_lat[i];
      end else begin : g_bn
        assign p2_dir[i] = p2_dir_reg[1];
        assign p2_oe[i]  = p2_func_own[i] ? p2_func_oe[i] : p2_lat_oe[i];
        assign p2_out[i] = p2_func_own[i] ? p2_func_out[i] : p2_lat[i];
      end
    end
  endgenerate

  ppc_pin_port #(.WIDTH(8)) u_p2 (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .wr_en   (wr_p2),
    .wr_data (wdata),
    .dir     (p2_dir),
    .pin_in  (p2_in),
    .pin_out (p2_lat),
    .pin_oe  (p2_lat_oe),
    .rd_data (p2_rd)
  );

  ppc_pin_port #(.WIDTH(8)) u_p6 (
    .mclk    (mclk),
    .rst_n   (rst_n),
    .wr_en   (wr_p6),
    .wr_data (wdata),
    .dir     (p6_dir_reg),
    .pin_in  (p6_in),
    .pin_out (p6_out),
    .pin_oe  (p6_oe),
    .rd_data (p6_rd)
  );

  // read data registered; direction registers and unmapped read zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= PPC_BYTE_ZERO;
    end else if (sel && rd) begin
      unique case (addr)
        PPC_ADDR_P2_DATA: rdata_reg <= p2_rd;
        PPC_ADDR_CTRL:    rdata_reg <= ctrl_reg;
        PPC_ADDR_P5_DATA: rdata_reg <= p5_in;
        PPC_ADDR_P6_DATA: rdata_reg <= p6_rd;
        default:          rdata_reg <= PPC_BYTE_ZERO;
      endcase
    end
  end
  assign rdata = rdata_reg;

  // port 5 function paths, idle high when disabled
  assign p5_func.int1_n = ctrl_reg[PPC_CTRL_INT1] ? p5_in[0] : 1'b1;
  assign p5_func.int2_n = ctrl_reg[PPC_CTRL_INT2] ? p5_in[1] : 1'b1;
  assign p5_func.mem_wait_n = ctrl_reg[PPC_CTRL_WAIT] ? p5_in[2] : 1'b1;
  assign p5_func.stop_n = ctrl_reg[PPC_CTRL_STOP] ? p5_in[3] : 1'b1;
  assign wake_int1_ok = ctrl_reg[PPC_CTRL_INT1];
  assign wake_int2_ok = ctrl_reg[PPC_CTRL_INT2];
  // stretch is asserted while the enabled wait input is low and no internal register is accessed
  assign clk_stretch = ctrl_reg[PPC_CTRL_WAIT] && !p5_in[2] && !internal_hit;

  assign ctrl.ext_int1_pin_enable = ctrl_reg[PPC_CTRL_INT1];
  assign ctrl.ext_int2_pin_enable = ctrl_reg[PPC_CTRL_INT2];
  assign ctrl.mem_wait_pin_enable = ctrl_reg[PPC_CTRL_WAIT];
  assign ctrl.stop_pin_enable     = ctrl_reg[PPC_CTRL_STOP];
  assign ctrl.internal_ram_enable = ctrl_reg[PPC_CTRL_RAM];
  assign ctrl.standby_supply_flag = ctrl_reg[PPC_CTRL_STBY];

  // expected read-back of an i/o port, rebuilt per bit for the checks
  logic [7:0] p2_mix;
  logic [7:0] p6_mix;
  assign p2_mix = (p2_in & ~p2_dir) | (p2_lat & p2_dir);
  assign p6_mix = (p6_in & ~p6_dir_reg) | (p6_out & p6_dir_reg);

  // bus steps that the checks below start from
  sequence s_rd_ctrl;
    sel && rd && (addr == PPC_ADDR_CTRL);
  endsequence

  sequence s_rd_p2;
    sel && rd && (addr == PPC_ADDR_P2_DATA);
  endsequence

  sequence s_rd_p5;
    sel && rd && (addr == PPC_ADDR_P5_DATA);
  endsequence

  sequence s_rd_p6;
    sel && rd && (addr == PPC_ADDR_P6_DATA);
  endsequence

  sequence s_rd_dir;
    sel && rd && (addr == PPC_ADDR_P6_DIR || addr == PPC_ADDR_P2_DIR);
  endsequence

  // software write only counts when no supply loss clears the flag at once
  sequence s_wr_ctrl;
    wr_ctrl && !supply_lost;
  endsequence

  sequence s_wr_p6;
    wr_p6;
  endsequence

  AST_P2_RESET_INPUT: assert property (@(posedge mclk)
    $rose(rst_n)
      |-> (p2_oe & ~p2_func_own) == PPC_BYTE_ZERO)
    else $error("port 2 drives after reset");
  AST_P6_RESET_INPUT: assert property (@(posedge mclk)
    $rose(rst_n)
      |-> p6_oe == PPC_BYTE_ZERO)
    else $error("port 6 drives after reset");
  AST_RAM_RESET: assert property (@(posedge mclk)
    $rose(rst_n)
      |-> ctrl.internal_ram_enable && ctrl.mem_wait_pin_enable)
    else $error("control reset value wrong");
  AST_INT_RESET: assert property (@(posedge mclk)
    $rose(rst_n)
      |-> !ctrl.ext_int1_pin_enable && !ctrl.ext_int2_pin_enable && ctrl.stop_pin_enable)
    else $error("interrupt or stop enable reset wrong");

  AST_P2_DIR_SPLIT: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_p2_dir ##1 (p2_func_own == PPC_BYTE_ZERO)
      |-> p2_oe == {{7{$past(wdata[1])}}, $past(wdata[0])})
    else $error("port 2 direction split wrong");
  AST_P2_UNOWNED: assert property (@(posedge mclk) disable iff (!rst_n)
    (p2_oe[7:1] & ~p2_func_own[7:1])
      == ({7{p2_dir_reg[1]}} & ~p2_func_own[7:1]))
    else $error("port 2 upper pins ignore direction bit 1");
  AST_P2_FUNC_OWN: assert property (@(posedge mclk) disable iff (!rst_n)
    (p2_oe[7:1] & p2_func_own[7:1])
      == (p2_func_oe[7:1] & p2_func_own[7:1]))
    else $error("function did not own port 2 direction");
  AST_P2_FUNC_OUT: assert property (@(posedge mclk) disable iff (!rst_n)
    (p2_out[7:1] & p2_func_own[7:1])
      == (p2_func_out[7:1] & p2_func_own[7:1]))
    else $error("function did not own port 2 level");
  AST_P2_PIN0_DIR: assert property (@(posedge mclk) disable iff (!rst_n)
    p2_oe[0]
      == p2_dir_reg[0])
    else $error("port 2 pin 0 taken by a function");
  AST_P2_DIR_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    !wr_p2_dir
      |=> $stable(p2_dir_reg))
    else $error("port 2 direction changed without write");

  AST_P6_DIR: assert property (@(posedge mclk) disable iff (!rst_n)
    wr_p6_dir
      |=> p6_oe == $past(wdata))
    else $error("port 6 direction not written");
  AST_P6_DIR_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    !wr_p6_dir
      |=> $stable(p6_dir_reg))
    else $error("port 6 direction changed without write");
  AST_P6_OUT_LATCH: assert property (@(posedge mclk) disable iff (!rst_n)
    s_wr_p6
      |=> p6_out == $past(wdata))
    else $error("port 6 latch not written");

  AST_INT_GATE: assert property (@(posedge mclk) disable iff (!rst_n)
    !ctrl.ext_int1_pin_enable
      |-> p5_func.int1_n && !wake_int1_ok)
    else $error("interrupt 1 passed while disabled");
  AST_INT2_GATE: assert property (@(posedge mclk) disable iff (!rst_n)
    !ctrl.ext_int2_pin_enable
      |-> p5_func.int2_n && !wake_int2_ok)
    else $error("interrupt 2 passed while disabled");
  AST_INT1_ROUTE: assert property (@(posedge mclk) disable iff (!rst_n)
    ctrl.ext_int1_pin_enable
      |-> p5_func.int1_n == p5_in[0] && wake_int1_ok)
    else $error("interrupt 1 input not routed");
  AST_INT2_ROUTE: assert property (@(posedge mclk) disable iff (!rst_n)
    ctrl.ext_int2_pin_enable
      |-> p5_func.int2_n == p5_in[1] && wake_int2_ok)
    else $error("interrupt 2 input not routed");
  AST_WAIT_GATE: assert property (@(posedge mclk) disable iff (!rst_n)
    !ctrl.mem_wait_pin_enable
      |-> p5_func.mem_wait_n && !clk_stretch)
    else $error("memory wait active while disabled");
  AST_WAIT_ROUTE: assert property (@(posedge mclk) disable iff (!rst_n)
    ctrl.mem_wait_pin_enable
      |-> p5_func.mem_wait_n == p5_in[2])
    else $error("memory wait input not routed");
  AST_STOP_GATE: assert property (@(posedge mclk) disable iff (!rst_n)
    ctrl.stop_pin_enable
      |-> p5_func.stop_n == p5_in[3])
    else $error("stop input not routed");
  AST_STOP_GATE_OFF: assert property (@(posedge mclk) disable iff (!rst_n)
    !ctrl.stop_pin_enable
      |-> p5_func.stop_n)
    else $error("stop active while disabled");

  AST_STRETCH_LOW: assert property (@(posedge mclk) disable iff (!rst_n)
    ctrl.mem_wait_pin_enable && !p5_in[2] && !sel
      |-> clk_stretch)
    else $error("low wait input did not stretch");
  AST_STRETCH_INTERNAL: assert property (@(posedge mclk) disable iff (!rst_n)
    internal_hit
      |-> !clk_stretch)
    else $error("stretch during internal access");

  AST_STBY_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
    supply_lost
      |=> !ctrl.standby_supply_flag)
    else $error("standby flag not cleared");
  AST_STBY_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
    s_wr_ctrl
      |=> ctrl.standby_supply_flag == $past(wdata[PPC_CTRL_STBY]))
    else $error("standby flag not written");
  AST_RAM_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
    s_wr_ctrl
      |=> ctrl.internal_ram_enable == $past(wdata[PPC_CTRL_RAM]))
    else $error("ram enable not written");
  AST_CTRL_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    !wr_ctrl && !supply_lost
      |=> $stable(ctrl_reg))
    else $error("control changed without cause");
  AST_CTRL_UNUSED: assert property (@(posedge mclk) disable iff (!rst_n)
    s_rd_ctrl
      |=> rdata[5:4] == 2'h0)
    else $error("unused control bits read set");
  AST_CTRL_WRITE: assert property (@(posedge mclk) disable iff (!rst_n)
    s_wr_ctrl
      |=> ctrl_reg == ($past(wdata) & PPC_CTRL_WMASK))
    else $error("control write value wrong");

  AST_DIR_WO: assert property (@(posedge mclk) disable iff (!rst_n)
    s_rd_dir
      |=> rdata == PPC_BYTE_ZERO)
    else $error("direction register readable");
  AST_CTRL_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    s_rd_ctrl
      |=> rdata == $past(ctrl_reg))
    else $error("control read wrong");
  AST_P5_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    s_rd_p5
      |=> rdata == $past(p5_in))
    else $error("port 5 read wrong");
  AST_P2_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    s_rd_p2
      |=> rdata == $past(p2_mix))
    else $error("port 2 read mixes pins and latch wrongly");
  AST_P6_READ: assert property (@(posedge mclk) disable iff (!rst_n)
    s_rd_p6
      |=> rdata == $past(p6_mix))
    else $error("port 6 read mixes pins and latch wrongly");
  AST_READ_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    !(sel && rd)
      |=> $stable(rdata))
    else $error("read data changed without read");

  AST_ACC_SPLIT: assert property (@(posedge mclk) disable iff (!rst_n)
    sel && (rd || wr)
      |-> ext_pass != internal_hit)
    else $error("access both or neither internal and external");
  AST_IDLE_NO_HIT: assert property (@(posedge mclk) disable iff (!rst_n)
    !sel
      |-> !ext_pass && !internal_hit)
    else $error("decode active without select");
endmodule
`default_nettype wire

// File: verification/ppc_pin_board.sv
`timescale 1ns/1ps
`default_nettype none
// board side of a port: an undriven pin shows the board level, never the last drive
module ppc_pin_board (
  input  wire logic [7:0] drv,
  input  wire logic [7:0] oe,
  input  wire logic [7:0] ext,
  output logic      [7:0] lvl
);
  assign lvl = (drv & oe) | (ext & ~oe);
endmodule
`default_nettype wire

// File: verification/test_parallel_ports_ram_port5_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_parallel_ports_ram_port5_control;
  import ppc_pkg::*;
  logic         mclk, rst_n, sel, rd, wr, supply_lost;
  logic   [4:0] addr;
  logic   [7:0] wdata, rdata, p2_in, p2_out, p2_oe, p2_ext, p6_in, p6_out, p6_oe, p6_ext;
  logic   [7:0] p5_in, p2_func_own, p2_func_oe, p2_func_out;
  logic         internal_hit, ext_pass, wake_int1_ok, wake_int2_ok, clk_stretch;
  ppc_p5_func_t p5_func;
  ppc_ctrl_t    ctrl;
  int           err_count, n_compared;

  ppc_top i_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .sel(sel), .rd(rd), .wr(wr),
    .wdata(wdata), .rdata(rdata), .internal_hit(internal_hit), .ext_pass(ext_pass),
    .p2_in(p2_in), .p2_out(p2_out), .p2_oe(p2_oe), .p2_func_own(p2_func_own),
    .p2_func_oe(p2_func_oe), .p2_func_out(p2_func_out), .p5_in(p5_in), .p5_func(p5_func),
    .wake_int1_ok(wake_int1_ok), .wake_int2_ok(wake_int2_ok), .p6_in(p6_in),
    .p6_out(p6_out), .p6_oe(p6_oe), .supply_lost(supply_lost), .ctrl(ctrl),
    .clk_stretch(clk_stretch));
  ppc_pin_board i_p2 (.drv(p2_out), .oe(p2_oe), .ext(p2_ext), .lvl(p2_in));
  ppc_pin_board i_p6 (.drv(p6_out), .oe(p6_oe), .ext(p6_ext), .lvl(p6_in));

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk) #5;
    sel = 1'b1;
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge mclk) #5;
    sel = 1'b0;
    wr = 1'b0;
  endtask

  task automatic rd_reg(input logic [4:0] a, input logic [7:0] exp, input string nm);
    @(posedge mclk) #5;
    sel = 1'b1;
    rd = 1'b1;
    addr = a;
    @(posedge mclk) #5;
    sel = 1'b0;
    rd = 1'b0;
    chk(nm, exp, rdata);
  endtask

  task automatic results();
    if (err_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // about 60 cycles of work; four thousand is ample
  initial begin
    #200000;
    err_count++;
    results();
  end

  initial begin
    rst_n = 1'b0;
    {sel, rd, wr, supply_lost, addr, wdata} = '0;
    {p2_func_own, p2_func_oe, p2_func_out} = '0;
    p2_ext = 8'h5a;
    p6_ext = 8'hf0;
    p5_in = 8'hf0;
    repeat (16) @(posedge mclk);
    #5 rst_n = 1'b1;
    chk("p2_oe", 8'h00, p2_oe);
    chk("p6_oe", 8'h00, p6_oe);
    chk("ctrl", 8'h0e, {2'h0, ctrl});
    chk("p5_func", 8'h0c, {4'h0, p5_func});
    chk("clk_stretch", 8'h01, {7'h0, clk_stretch});
    rd_reg(PPC_ADDR_CTRL, 8'h4c, "ctrl_rd");
    rd_reg(PPC_ADDR_P2_DIR, 8'h00, "p2_dir_rd");
    rd_reg(PPC_ADDR_P6_DIR, 8'h00, "p6_dir_rd");
    wr_reg(PPC_ADDR_P5_DATA, 8'h00);
    rd_reg(PPC_ADDR_P5_DATA, 8'hf0, "p5_rd");
    // plain inputs on pins 2 and 3 need both enables cleared first
    wr_reg(PPC_ADDR_CTRL, 8'h03);
    chk("p5_func_irq", 8'h03, {4'h0, p5_func});
    chk("wake_ok", 8'h03, {6'h0, wake_int1_ok, wake_int2_ok});
    chk("clk_stretch_off", 8'h00, {7'h0, clk_stretch});
    wr_reg(PPC_ADDR_CTRL, 8'hff);
    rd_reg(PPC_ADDR_CTRL, 8'hcf, "ctrl_ff");
    @(posedge mclk) #5 supply_lost = 1'b1;
    @(posedge mclk) #5 supply_lost = 1'b0;
    rd_reg(PPC_ADDR_CTRL, 8'h4f, "ctrl_lost");
    wr_reg(PPC_ADDR_P2_DATA, 8'ha5);
    wr_reg(PPC_ADDR_P2_DIR, 8'h01);
    chk("p2_oe_b0", 8'h01, p2_oe);
    wr_reg(PPC_ADDR_P2_DIR, 8'h02);
    chk("p2_oe_b1", 8'hfe, p2_oe);
    chk("p2_drive", 8'ha4, p2_out & p2_oe);
    rd_reg(PPC_ADDR_P2_DATA, 8'ha4, "p2_rd");
    p2_func_own = 8'h23;
    p2_func_oe = 8'h21;
    #1 chk("p2_oe_func", 8'hfc, p2_oe);
    chk("p2_out5_func", 8'h00, {7'h0, p2_out[5]});
    @(posedge mclk) #5 p2_func_own = 8'h00;
    wr_reg(PPC_ADDR_P6_DIR, 8'h0f);
    wr_reg(PPC_ADDR_P6_DATA, 8'h3c);
    chk("p6_oe", 8'h0f, p6_oe);
    chk("p6_drive", 8'h0c, p6_out & p6_oe);
    rd_reg(PPC_ADDR_P6_DATA, 8'hfc, "p6_rd");
    wr_reg(PPC_ADDR_CTRL, 8'h0f);
    chk("ctrl_ram_off", 8'h3c, {2'h0, ctrl});
    @(posedge mclk) #5;
    sel = 1'b1;
    rd = 1'b1;
    addr = 5'h02;
    #1 chk("ext_addr", 8'h02, {6'h0, ext_pass, internal_hit});
    @(posedge mclk) #5 addr = 5'h12;
    #1 chk("rx_addr", 8'h01, {6'h0, ext_pass, internal_hit});
    @(posedge mclk) #5 addr = 5'h18;
    #1 chk("ext_addr_hi", 8'h02, {6'h0, ext_pass, internal_hit});
    @(posedge mclk) #5 addr = PPC_ADDR_P6_DATA;
    #1 chk("int_addr", 8'h01, {6'h0, ext_pass, internal_hit});
    @(posedge mclk) #5;
    sel = 1'b0;
    rd = 1'b0;
    rst_n = 1'b0;
    #1 chk("p6_oe_rst", 8'h00, p6_oe);
    chk("p2_oe_rst", 8'h00, p2_oe);
    @(posedge mclk) #5 rst_n = 1'b1;
    rd_reg(PPC_ADDR_CTRL, 8'h4c, "ctrl_rst");
    results();
  end
endmodule
`default_nettype wire
